// file: clkcfg_defs.svh
// Constant definitions for the clock generator configuration port
`ifndef CLKCFG_DEFS_SVH
`define CLKCFG_DEFS_SVH

// Fixed seven-bit bus target address
`define CLKCFG_TARGET_ADDR  7'h6A

// Command byte low-bit codes
`define CLKCFG_CMD_WRITE    2'h0
`define CLKCFG_CMD_SAVE     2'h1
`define CLKCFG_CMD_RESTORE  2'h2

// Select pin codes, {high, low}
`define CLKCFG_SEL_SLEEP    2'h0
`define CLKCFG_SEL_SLOT0    2'h1
`define CLKCFG_SEL_SLOT1    2'h2
`define CLKCFG_SEL_SLOT2    2'h3

// Active slot encoding on the status output
`define CLKCFG_SLOT_ZERO    2'h0
`define CLKCFG_SLOT_ONE     2'h1
`define CLKCFG_SLOT_TWO     2'h2

// Link bit counter: last data bit and acknowledge slot
`define CLKCFG_BIT_LAST     4'h7
`define CLKCFG_BIT_ACK      4'h8

// Bits still to send after the first bit of a byte
`define CLKCFG_TX_REST      3'h7

// Register address width
`define CLKCFG_ADDR_W       8

`endif

// file: clkcfg_pkg.sv
// Types shared by the configuration port files
`default_nettype none
package clkcfg_pkg;

   // Frame states, Gray coded along the usual path
   typedef enum logic [2:0] {
      clkcfg_st_idle  = 3'h0,
      clkcfg_st_addr  = 3'h1,
      clkcfg_st_cmd   = 3'h3,
      clkcfg_st_reg   = 3'h2,
      clkcfg_st_wdata = 3'h6,
      clkcfg_st_rdata = 3'h7,
      clkcfg_st_waitp = 3'h5,
      clkcfg_st_busy  = 3'h4
   } clkcfg_state_t;

   // Nonvolatile copy direction
   typedef enum logic {
      clkcfg_op_save    = 1'b0,
      clkcfg_op_restore = 1'b1
   } clkcfg_op_t;

endpackage

`default_nettype wire

// file: clkcfg_sync.sv
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module clkcfg_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);

   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

`default_nettype wire

// file: clkcfg_mem.sv
// Single-port byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module clkcfg_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input  wire logic          clk,
   input  wire logic          ce,
   input  wire logic          en,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output var  logic [DW-1:0] rdata
);

   logic [DW-1:0] store [0:(1<<AW)-1];

   // Write port
   always_ff @(posedge clk) begin
      if (ce && en && we) begin
         store[addr] <= wdata;
      end
   end

   // Read data held until the next read
   always_ff @(posedge clk) begin
      if (ce && en && !we) begin
         rdata <= store[addr];
      end
   end

endmodule

`default_nettype wire

// file: clkcfg_port.sv
// Two-wire configuration port of the clock generator
`timescale 1ns/1ps
`default_nettype none
`include "clkcfg_defs.svh"

module clkcfg_port
   import clkcfg_pkg::*;
#(
   parameter int AW = `CLKCFG_ADDR_W
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       scl,
   input  wire logic       sda_i,
   output var  logic       sda_o,
   output var  logic       sda_oe,
   input  wire logic       setting_select_low,
   input  wire logic       setting_select_high,
   output var  logic       clk_out_en,
   output var  logic       power_down,
   output var  logic [1:0] active_slot,
   output var  logic       cfg_busy
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [3:0]    link_bits;
   logic [7:0]    link_shift;
   logic [7:0]    rx_byte;
   logic          byte_tgl;
   logic          ack_tgl;
   logic          master_ack;
   logic          link_clr;
   logic          rel_pend;

   logic [5:0]    sync_out;
   logic          scl_s;
   logic          sda_s;
   logic          btg_s;
   logic          atg_s;
   logic [1:0]    sel_s;
   logic          scl_q;
   logic          sda_q;
   logic          btg_q;
   logic          atg_q;
   logic          start_ev;
   logic          stop_ev;
   logic          scl_fall;
   logic          byte_ev;
   logic          ack_ev;

   clkcfg_state_t state;
   clkcfg_op_t    op;
   clkcfg_op_t    pend_op;
   logic          pend_valid;
   logic [AW-1:0] ptr;
   logic          acc_en;
   logic          acc_we;
   logic [AW-1:0] acc_addr;
   logic [7:0]    acc_wdata;
   logic          ack_req;
   logic          send_req;

   logic          ack_arm;
   logic          tx_go;
   logic          tx_on;
   logic [2:0]    tx_left;
   logic [7:0]    tx_sh;

   logic [AW:0]   cp_cnt;
   logic          cp_v;
   logic [AW-1:0] cp_a;
   logic          busy;
   logic          restoring;
   logic          rd_live;
   logic          cp_done;

   logic          cfg_en;
   logic          cfg_we;
   logic [AW-1:0] cfg_addr;
   logic [7:0]    cfg_wdata;
   logic [7:0]    cfg_rdata;
   logic          nv_en;
   logic          nv_we;
   logic [AW-1:0] nv_addr;
   logic [7:0]    nv_rdata;

   // ---------------------------------------------------------------
   // Link clock domain: bit shifter
   // ---------------------------------------------------------------

   // Bit counter and shifter, cleared between frames
   always_ff @(posedge scl or posedge link_clr) begin
      if (link_clr) begin
         link_bits  <= 4'h0;
         link_shift <= 8'h00;
      end else if (link_bits == `CLKCFG_BIT_ACK) begin
         link_bits <= 4'h0;
      end else begin
         link_shift <= {link_shift[6:0], sda_i};
         link_bits  <= link_bits + 4'h1;
      end
   end

   // Byte and acknowledge events as toggles for the crossing
   always_ff @(posedge scl or posedge rst) begin
      if (rst) begin
         rx_byte    <= 8'h00;
         byte_tgl   <= 1'b0;
         ack_tgl    <= 1'b0;
         master_ack <= 1'b0;
      end else if (link_bits == `CLKCFG_BIT_LAST) begin
         rx_byte  <= {link_shift[6:0], sda_i};
         byte_tgl <= ~byte_tgl;
      end else if (link_bits == `CLKCFG_BIT_ACK) begin
         master_ack <= ~sda_i; // Low level is an acknowledge
         ack_tgl    <= ~ack_tgl;
      end
   end

   // ---------------------------------------------------------------
   // Crossing into the reference clock domain
   // ---------------------------------------------------------------
   clkcfg_sync #(
      .W (6)
   ) u_sync (
      .clk  (ref_clk),
      .rst  (rst),
      .din  ({setting_select_high, setting_select_low, ack_tgl, byte_tgl, sda_i, scl}),
      .dout (sync_out)
   );

   assign scl_s = sync_out[0];
   assign sda_s = sync_out[1];
   assign btg_s = sync_out[2];
   assign atg_s = sync_out[3];
   assign sel_s = sync_out[5:4];

   // Previous values for edge detection
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b0;
         sda_q <= 1'b1;
         btg_q <= 1'b0;
         atg_q <= 1'b0;
      end else if (ce) begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         btg_q <= btg_s;
         atg_q <= atg_s;
      end
   end

   // Bus conditions and link events
   assign start_ev = scl_s && scl_q && sda_q && !sda_s;
   assign stop_ev  = scl_s && scl_q && !sda_q && sda_s;
   assign scl_fall = scl_q && !scl_s;
   assign byte_ev  = btg_s ^ btg_q;
   assign ack_ev   = atg_s ^ atg_q;

   // Link clear: held outside frames, dropped once clock is low after start
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         link_clr <= 1'b1;
         rel_pend <= 1'b0;
      end else if (ce) begin
         if (stop_ev) begin
            link_clr <= 1'b1;
            rel_pend <= 1'b0;
         end else if (start_ev) begin
            link_clr <= 1'b1; // Repeated start restarts the bit count
            rel_pend <= 1'b1;
         end else if (rel_pend && !scl_s) begin
            link_clr <= 1'b0;
            rel_pend <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Frame state machine
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state      <= clkcfg_st_busy; // Power-up load before traffic
         op         <= clkcfg_op_restore;
         pend_op    <= clkcfg_op_save;
         pend_valid <= 1'b0;
         ptr        <= '0;
         acc_en     <= 1'b0;
         acc_we     <= 1'b0;
         acc_addr   <= '0;
         acc_wdata  <= 8'h00;
         ack_req    <= 1'b0;
         send_req   <= 1'b0;
      end else if (ce) begin
         acc_en   <= 1'b0;
         acc_we   <= 1'b0;
         ack_req  <= 1'b0;
         send_req <= 1'b0;
         if (state == clkcfg_st_busy) begin
            if (cp_done) begin
               state <= clkcfg_st_idle; // Acknowledging resumes
            end
         end else if (stop_ev) begin
            if (pend_valid) begin
               state <= clkcfg_st_busy; // Copy begins only at stop
               op    <= pend_op;
            end else begin
               state <= clkcfg_st_idle;
            end
            pend_valid <= 1'b0;
         end else if (start_ev) begin
            state      <= clkcfg_st_addr;
            pend_valid <= 1'b0;
         end else if (byte_ev) begin
            unique case (state)
               clkcfg_st_addr: begin
                  if (rx_byte[7:1] == `CLKCFG_TARGET_ADDR) begin
                     ack_req <= 1'b1;
                     if (rx_byte[0]) begin
                        state    <= clkcfg_st_rdata;
                        send_req <= 1'b1;
                        acc_en   <= 1'b1;
                        acc_addr <= ptr;
                     end else begin
                        state <= clkcfg_st_cmd;
                     end
                  end else begin
                     state <= clkcfg_st_waitp; // Foreign address ignored
                  end
               end
               clkcfg_st_cmd: begin
                  ack_req <= 1'b1;
                  unique case (rx_byte[1:0])
                     `CLKCFG_CMD_WRITE: begin
                        state <= clkcfg_st_reg;
                     end
                     `CLKCFG_CMD_SAVE: begin
                        pend_op    <= clkcfg_op_save;
                        pend_valid <= 1'b1;
                        state      <= clkcfg_st_waitp;
                     end
                     `CLKCFG_CMD_RESTORE: begin
                        pend_op    <= clkcfg_op_restore;
                        pend_valid <= 1'b1;
                        state      <= clkcfg_st_waitp;
                     end
                     default: begin
                        state <= clkcfg_st_waitp;
                     end
                  endcase
               end
               clkcfg_st_reg: begin
                  ack_req <= 1'b1;
                  ptr     <= rx_byte[AW-1:0]; // Leading byte sets pointer
                  state   <= clkcfg_st_wdata;
               end
               clkcfg_st_wdata: begin
                  ack_req   <= 1'b1;
                  acc_en    <= 1'b1; // Live rewrite whenever no save or restore copy is running
                  acc_we    <= 1'b1;
                  acc_addr  <= ptr;
                  acc_wdata <= rx_byte;
                  ptr       <= ptr + 1'b1;
               end
               clkcfg_st_idle, clkcfg_st_rdata, clkcfg_st_waitp, clkcfg_st_busy: begin
               end
            endcase
         end else if (ack_ev && state == clkcfg_st_rdata && !tx_go) begin // Own address ack skipped
            ptr <= ptr + 1'b1; // Step after each byte read
            if (master_ack) begin
               acc_en   <= 1'b1; // Fetch the next register
               acc_addr <= ptr + 1'b1;
               send_req <= 1'b1;
            end else begin
               state <= clkcfg_st_waitp; // Last byte answered high
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Data line drive, changed on falling clock edges
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sda_oe  <= 1'b0;
         ack_arm <= 1'b0;
         tx_go   <= 1'b0;
         tx_on   <= 1'b0;
         tx_left <= 3'h0;
         tx_sh   <= 8'h00;
      end else if (ce) begin
         if (start_ev || stop_ev) begin
            sda_oe  <= 1'b0;
            ack_arm <= 1'b0;
            tx_go   <= 1'b0;
            tx_on   <= 1'b0;
         end else if (scl_fall) begin
            if (ack_arm) begin
               sda_oe  <= 1'b1; // Hold low through the ack slot
               ack_arm <= 1'b0;
            end else if (tx_go) begin
               sda_oe  <= ~cfg_rdata[7]; // Most significant bit first
               tx_sh   <= {cfg_rdata[6:0], 1'b0};
               tx_left <= `CLKCFG_TX_REST;
               tx_on   <= 1'b1;
               tx_go   <= 1'b0;
            end else if (tx_on && tx_left != 3'h0) begin
               sda_oe  <= ~tx_sh[7];
               tx_sh   <= {tx_sh[6:0], 1'b0};
               tx_left <= tx_left - 3'h1;
            end else begin
               sda_oe <= 1'b0; // Release for the controller's answer
               tx_on  <= 1'b0;
            end
         end
         // Requests win over a clear in the same cycle
         if (ack_req) begin
            ack_arm <= 1'b1;
         end
         if (send_req) begin
            tx_go <= 1'b1;
         end
      end
   end

   // Open-drain low level
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Save and restore copy engine
   // ---------------------------------------------------------------
   assign busy      = (state == clkcfg_st_busy);
   assign restoring = busy && (op == clkcfg_op_restore);
   assign rd_live   = busy && !cp_cnt[AW];
   assign cp_done   = cp_cnt[AW] && !cp_v;

   // Read address walk and delayed write address
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cp_cnt <= '0;
         cp_v   <= 1'b0;
         cp_a   <= '0;
      end else if (ce) begin
         if (!busy) begin
            cp_cnt <= '0;
            cp_v   <= 1'b0;
         end else begin
            cp_v <= rd_live;
            cp_a <= cp_cnt[AW-1:0];
            if (rd_live) begin
               cp_cnt <= cp_cnt + 1'b1; // Whole store copied
            end
         end
      end
   end

   // Port steering: bus accesses or copy
   assign cfg_en    = busy ? (restoring ? cp_v : rd_live) : acc_en;
   assign cfg_we    = busy ? restoring : acc_we;
   assign cfg_addr  = busy ? (restoring ? cp_a : cp_cnt[AW-1:0]) : acc_addr;
   assign cfg_wdata = busy ? nv_rdata : acc_wdata;
   assign nv_en     = busy && (restoring ? rd_live : cp_v);
   assign nv_we     = busy && !restoring;
   assign nv_addr   = restoring ? cp_cnt[AW-1:0] : cp_a;

   clkcfg_mem #(
      .AW (AW),
      .DW (8)
   ) u_cfg_regs (
      .clk   (ref_clk),
      .ce    (ce),
      .en    (cfg_en),
      .we    (cfg_we),
      .addr  (cfg_addr),
      .wdata (cfg_wdata),
      .rdata (cfg_rdata)
   );

   clkcfg_mem #(
      .AW (AW),
      .DW (8)
   ) u_nv_store (
      .clk   (ref_clk),
      .ce    (ce),
      .en    (nv_en),
      .we    (nv_we),
      .addr  (nv_addr),
      .wdata (cfg_rdata),
      .rdata (nv_rdata)
   );

   // ---------------------------------------------------------------
   // Select decode and status
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         power_down  <= 1'b0;
         active_slot <= `CLKCFG_SLOT_ZERO;
         clk_out_en  <= 1'b0;
         cfg_busy    <= 1'b1;
      end else if (ce) begin
         power_down <= (sel_s == `CLKCFG_SEL_SLEEP);
         unique case (sel_s)
            `CLKCFG_SEL_SLOT0: active_slot <= `CLKCFG_SLOT_ZERO;
            `CLKCFG_SEL_SLOT1: active_slot <= `CLKCFG_SLOT_ONE;
            `CLKCFG_SEL_SLOT2: active_slot <= `CLKCFG_SLOT_TWO;
            `CLKCFG_SEL_SLEEP: active_slot <= active_slot;
         endcase
         clk_out_en <= !restoring && (sel_s != `CLKCFG_SEL_SLEEP);
         cfg_busy   <= busy;
      end
   end

endmodule

`default_nettype wire

// file: clkcfg_port_properties.sv
// Port assertions for the clock generator configuration port
`timescale 1ns/1ps
`default_nettype none
module clkcfg_port_properties #(
   parameter int AW = 8
) (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       ce,
   input wire logic       scl,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic       setting_select_low,
   input wire logic       setting_select_high,
   input wire logic       clk_out_en,
   input wire logic       power_down,
   input wire logic [1:0] active_slot,
   input wire logic       cfg_busy
);
   localparam int PU = 1 << AW;
   logic [1:0]  pins;
   logic [AW:0] since_rst;

   assign pins = {setting_select_high, setting_select_low};
   // Enabled cycles since reset release, saturating
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         since_rst <= '0;
      end else if (ce && !since_rst[AW]) begin
         since_rst <= since_rst + 1'b1;
      end
   end

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   sequence s_pins_steady;
      $stable(pins) [*6];
   endsequence
   property p_busy_quiet;
      cfg_busy |-> !sda_oe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("ack while busy");
   property p_powerup;
      (since_rst < PU) |-> cfg_busy && !clk_out_en;
   endproperty
   a_powerup: assert property (p_powerup) else $error("early power-up end");
   property p_busy_at_stop;
      $rose(cfg_busy) |-> scl && sda_i;
   endproperty
   a_busy_at_stop: assert property (p_busy_at_stop) else $error("copy not at stop");
   property p_oe_scl_low;
      $changed(sda_oe) |-> !scl;
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
   property p_open_drain;
      sda_oe |-> !sda_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("data driven high");
   property p_sleep;
      s_pins_steady ##0 (pins == 2'h0) |-> power_down && !clk_out_en;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep decode");
   property p_slot;
      s_pins_steady ##0 (pins != 2'h0) |-> !power_down && active_slot == pins - 2'h1;
   endproperty
   a_slot: assert property (p_slot) else $error("slot decode");
   property p_awake;
      (!cfg_busy && pins != 2'h0) [*6] |-> clk_out_en;
   endproperty
   a_awake: assert property (p_awake) else $error("outputs held off");
endmodule
`default_nettype wire

// file: clkcfg_host_model.sv
// Two-wire bus controller model facing the configuration port
`timescale 1ns/1ps
`default_nettype none
module clkcfg_host_model #(
   parameter int HALF = 6
) (
   output var  logic scl,
   output var  logic host_oe,
   input  wire logic sda_w
);
   // Idle bus: clock high, data released
   initial begin
      scl = 1'b1;
      host_oe = 1'b0;
   end
   // Start or repeated start: data falls while clock high
   task automatic bus_start();
      host_oe = 1'b0;
      #(6*HALF) scl = 1'b1;
      #(7*HALF) host_oe = 1'b1;
      #(7*HALF) scl = 1'b0;
      #(6*HALF);
   endtask
   // Stop: data rises while clock high
   task automatic bus_stop();
      #(HALF) host_oe = 1'b1;
      #(5*HALF) scl = 1'b1;
      #(7*HALF) host_oe = 0;
      #(10*HALF);
   endtask
   // Eight bits MSB first then the ack slot; low phase long enough for the answer
   task automatic bus_byte(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #1 host_oe = ~tx[i];
         #(6*HALF-1) rx[i] = sda_w;
         scl = 1'b1;
         #(2*HALF) scl = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// file: clkcfg_port_tb_top.sv
// Self-checking bench for the configuration port
`timescale 1ns/1ps
`default_nettype none
module clkcfg_port_tb_top;
   logic       ref_clk = 1'b0;
   logic       rst;
   logic       ce;
   logic       scl;
   logic       host_oe;
   logic       sda_w;
   logic       sda_o;
   logic       sda_oe;
   logic       setting_select_low;
   logic       setting_select_high;
   logic       clk_out_en;
   logic       power_down;
   logic [1:0] active_slot;
   logic       cfg_busy;
   logic [8:0] rx;
   int         bad_count = 0;
   int         check_count = 0;

   // 200 MHz system clock
   always #2.5 ref_clk = ~ref_clk;
   // Open-drain data line with pull-up
   assign sda_w = ((sda_oe && !sda_o) || host_oe) ? 1'b0 : 1'b1;

   clkcfg_port #(.AW(8)) i_clkcfg_port (
      .ref_clk             (ref_clk),
      .rst                 (rst),
      .ce                  (ce),
      .scl                 (scl),
      .sda_i               (sda_w),
      .sda_o               (sda_o),
      .sda_oe              (sda_oe),
      .setting_select_low  (setting_select_low),
      .setting_select_high (setting_select_high),
      .clk_out_en          (clk_out_en),
      .power_down          (power_down),
      .active_slot         (active_slot),
      .cfg_busy            (cfg_busy)
   );
   clkcfg_host_model i_host (
      .scl     (scl),
      .host_oe (host_oe),
      .sda_w   (sda_w)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      i_host.bus_byte({d, 1'b1}, rx);
      chk("ack", {7'h0, rx[0]}, 8'h00);
   endtask
   task automatic rd(input logic last, input logic [7:0] exp);
      i_host.bus_byte({8'hFF, last}, rx);
      chk("rdata", rx[8:1], exp);
   endtask
   // Start, whole bytes, optional stop
   task automatic frame(input logic [7:0] b[$], input logic stop);
      i_host.bus_start();
      foreach (b[i]) wr(b[i]);
      if (stop) i_host.bus_stop();
   endtask
   // Address retried until acked, nothing else sent meanwhile
   task automatic poll(output int n);
      n = 0;
      do begin
         n++;
         i_host.bus_start();
         i_host.bus_byte({8'hD4, 1'b1}, rx);
         i_host.bus_stop();
      end while (rx[0] !== 1'b0 && n < 60);
      chk("poll", {7'h0, rx[0]}, 8'h00);
      chk("retried", {7'h0, n > 1}, 8'h01);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_powerup();
      int n;
      chk("busy", {7'h0, cfg_busy}, 8'h01);
      chk("outs_off", {7'h0, clk_out_en}, 8'h00);
      poll(n);
      chk("outs_on", {7'h0, clk_out_en}, 8'h01);
      $display("powerup test done");
   endtask
   task automatic t_rw();
      frame('{8'hD4, 8'h00, 8'hFE, 8'hA5, 8'h5A, 8'hC3}, 1'b1);
      frame('{8'hD4, 8'h00, 8'hFE}, 1'b0);
      frame('{8'hD5}, 1'b0);
      rd(1'b0, 8'hA5);
      rd(1'b0, 8'h5A);
      rd(1'b1, 8'hC3);
      i_host.bus_stop();
      frame('{8'hD4, 8'hFC, 8'h10, 8'h11, 8'h22}, 1'b1);
      frame('{8'hD4, 8'h00, 8'h10}, 1'b1);
      frame('{8'hD5}, 1'b0);
      rd(1'b1, 8'h11);
      i_host.bus_stop();
      frame('{8'hD5}, 1'b0);
      rd(1'b1, 8'h22);
      i_host.bus_stop();
      $display("write read test done");
   endtask
   task automatic t_foreign();
      logic [7:0] adr[4] = '{8'hD6, 8'h54, 8'hD2, 8'hF5};
      foreach (adr[i]) begin
         i_host.bus_start();
         i_host.bus_byte({adr[i], 1'b1}, rx);
         chk("foreign", {7'h0, rx[0]}, 8'h01);
         i_host.bus_stop();
      end
      frame('{8'hD4, 8'h03}, 1'b0); // Command 11 acked, later bytes ignored
      i_host.bus_byte({8'h10, 1'b1}, rx);
      chk("cmd_rest", {7'h0, rx[0]}, 8'h01);
      i_host.bus_stop();
      $display("foreign address test done");
   endtask
   task automatic t_nv();
      int n;
      frame('{8'hD4, 8'hFD}, 1'b1);
      @(negedge ref_clk);
      chk("save_busy", {7'h0, cfg_busy}, 8'h01);
      poll(n);
      frame('{8'hD4, 8'h00, 8'h10, 8'h77}, 1'b1);
      frame('{8'hD4, 8'hAE}, 1'b1);
      @(negedge ref_clk);
      chk("restore_off", {7'h0, clk_out_en}, 8'h00);
      poll(n);
      frame('{8'hD4, 8'h00, 8'h10}, 1'b1);
      frame('{8'hD5}, 1'b0);
      rd(1'b1, 8'h11);
      i_host.bus_stop();
      $display("save restore test done");
   endtask
   task automatic t_select();
      logic [1:0] code;
      for (int c = 4; c >= 0; c--) begin
         code = (c == 4) ? 2'h1 : c[1:0];
         @(posedge ref_clk);
         setting_select_high <= code[1];
         setting_select_low <= code[0];
         repeat (10) @(posedge ref_clk);
         @(negedge ref_clk);
         chk("sleep", {7'h0, power_down}, {7'h0, code == 2'h0});
         chk("outs_en", {7'h0, clk_out_en}, {7'h0, code != 2'h0});
         chk("slot", {6'h0, active_slot}, {6'h0, (code == 2'h0) ? 2'h0 : code - 2'h1});
      end
      $display("select test done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence; pins held at 01 through reset
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      setting_select_high = 1'b0;
      setting_select_low = 1'b1;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      t_powerup();
      t_rw();
      t_foreign();
      t_nv();
      t_select();
      final_report();
   end
   // Watchdog well past the expected run
   initial begin
      #200000;
      bad_count++;
      final_report();
   end
endmodule

bind clkcfg_port clkcfg_port_properties #(.AW(AW)) i_clkcfg_port_properties (
   .ref_clk             (ref_clk),
   .rst                 (rst),
   .ce                  (ce),
   .scl                 (scl),
   .sda_i               (sda_i),
   .sda_o               (sda_o),
   .sda_oe              (sda_oe),
   .setting_select_low  (setting_select_low),
   .setting_select_high (setting_select_high),
   .clk_out_en          (clk_out_en),
   .power_down          (power_down),
   .active_slot         (active_slot),
   .cfg_busy            (cfg_busy)
);
`default_nettype wire
